/* hw/smf_pkg.sv */
/*
 Shared constants and types for the serial memory front end.
 Assumes an SPI master on the far side and a system clock beside it.
*/
package smf_pkg;
   // ==========================================================
   // Geometry
   localparam int SMF_ADDR_W = 18;
   localparam int SMF_MEM_BYTES = 262144;
   localparam int SMF_ADDR_BYTES = 3;
   localparam int SMF_BYTE_W = 8;

   // ==========================================================
   // Opcodes served here
   localparam logic [7:0] SMF_OP_WRITE = 8'h02;
   localparam logic [7:0] SMF_OP_READ = 8'h03;

   // ==========================================================
   // Bus limits and reset values
   localparam int SMF_SCK_MAX_MHZ = 25;
   localparam int SMF_BUF_DEPTH = 2;
   localparam logic [2:0] SMF_BIT_RST = 3'h0;
   localparam logic [1:0] SMF_ABYTE_RST = 2'h0;
   localparam logic [1:0] SMF_ABYTE_LAST = 2'h2;
   localparam logic [2:0] SMF_BIT_LAST = 3'h7;

   // ==========================================================
   // Types
   typedef enum logic [2:0]
   {
      SMF_ST_OP,
      SMF_ST_ADDR,
      SMF_ST_WDATA,
      SMF_ST_RDATA,
      SMF_ST_IGNORE
   } smf_state_t;

   typedef struct packed
   {
      logic [SMF_ADDR_W-1:0] addr;
      logic [SMF_BYTE_W-1:0] data;
   } smf_wrec_t;
endpackage

/* hw/smf_top.sv */
/*
 SPI slave front end of a byte wide serial memory, storage included.
 Link logic runs on the master's serial clock and is framed by chip
 select; written bytes are mirrored into the system clock domain through
 a two entry buffer, with an overrun flag for lost ones. Assumes a master using mode 0 or mode 3.
*/
// Behaviour
// [R1] 262144 byte locations, shifted serially
// [R2] Three address bytes, low 18 bits used
// [R3] Pure slave, up to 25 MHz clock
// [R4] Only modes 0 and 3 are used
// [R5] Sample input on rising clock after select
// [R6] Change output on falling clock edges
// [R7] First captured bit is opcode MSB
// [R8] Opcode first, then address, then data
// [R9] Master deselects before next opcode
// [R10] One opcode per select period
// [R11] Deselected: ignore input, output tristated
// [R12] Writes finish within the transfer
// [R13] Master drives clock and selects low
// [R14] Never starts a transaction itself
// [R15] Clock level at select fall sets mode
// [R16] Unknown opcode: ignore until reselect
// [R17] Address and data sent MSB first
// [R18] Deselect mid byte discards partial bits
`timescale 1ns/1ns
module smf_top
   import smf_pkg::*;
#(
   parameter int MEM_BYTES = SMF_MEM_BYTES,
   parameter int BUF_DEPTH = SMF_BUF_DEPTH
)
(
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic I_SI,
   output logic O_SO,
   output logic O_SO_OE,
   output logic O_WR_VALID,
   input wire logic I_WR_READY,
   output logic [SMF_ADDR_W-1:0] O_WR_ADDR,
   output logic [SMF_BYTE_W-1:0] O_WR_DATA,
   output logic O_OVERRUN
);

   // ==========================================================
   // Link domain: serial clock, reset by deselect
   smf_state_t state_r;
   logic [2:0] bit_r;
   logic [6:0] sh_r;
   logic [1:0] abyte_r;
   logic [SMF_ADDR_W-1:0] addr_r;
   logic [7:0] byte_in;
   logic byte_done;
   logic mem_we;
   logic mode3_r;
   logic rise_seen_r;
   logic [7:0] out_r;
   logic oe_r;
   logic rd_cmd_r;
   // Known start value; the system side only looks for changes
   logic wr_tgl_r = 1'b0;
   smf_wrec_t wr_hold_r;
   logic [SMF_BYTE_W-1:0] mem [MEM_BYTES];

   assign byte_in = {sh_r, I_SI}; // [R7] [R17]
   assign byte_done = (bit_r == SMF_BIT_LAST);
   assign mem_we = (state_r == SMF_ST_WDATA) && byte_done && !I_CS_N;

   // Mode sampled at the select edge; only 0 and 3 are meaningful
   always_ff @(negedge I_CS_N)
   begin
      mode3_r <= I_SCK; // [R15] [R4]
   end

   // Bit counter and shifter; deselect discards a partial byte
   always_ff @(posedge I_SCK or posedge I_CS_N) // [R3]
   begin
      if (I_CS_N)
      begin
         bit_r <= SMF_BIT_RST; // [R18] [R11]
         sh_r <= 7'h00;
      end
      else
      begin
         bit_r <= bit_r + 3'h1; // [R5]
         sh_r <= byte_in[6:0];
      end
   end

   // Command sequencer; back in opcode state only after deselect
   always_ff @(posedge I_SCK or posedge I_CS_N)
   begin
      if (I_CS_N)
      begin
         state_r <= SMF_ST_OP; // [R10] [R18]
         abyte_r <= SMF_ABYTE_RST;
      end
      else if (byte_done)
      begin
         case (state_r)
            SMF_ST_OP:
            begin
               if (byte_in == SMF_OP_WRITE || byte_in == SMF_OP_READ)
               begin
                  state_r <= SMF_ST_ADDR; // [R8]
               end
               else
               begin
                  state_r <= SMF_ST_IGNORE; // [R16]
               end
            end
            SMF_ST_ADDR:
            begin
               abyte_r <= abyte_r + 2'h1;
               if (abyte_r == SMF_ABYTE_LAST)
               begin
                  state_r <= rd_cmd_r ? SMF_ST_RDATA : SMF_ST_WDATA; // [R8]
               end
            end
            SMF_ST_WDATA,
            SMF_ST_RDATA,
            SMF_ST_IGNORE:
            begin
               state_r <= state_r; // [R10]
            end
            default:
            begin
               state_r <= SMF_ST_IGNORE;
            end
         endcase
      end
   end

   // Remember whether the opcode was a read
   always_ff @(posedge I_SCK or posedge I_CS_N)
   begin
      if (I_CS_N)
      begin
         rd_cmd_r <= 1'b0;
      end
      else if (byte_done && state_r == SMF_ST_OP)
      begin
         rd_cmd_r <= (byte_in == SMF_OP_READ);
      end
   end

   // Address: upper six bits shift out of the register and are lost
   always_ff @(posedge I_SCK or posedge I_CS_N)
   begin
      if (I_CS_N)
      begin
         addr_r <= '0;
      end
      else if (byte_done && state_r == SMF_ST_ADDR)
      begin
         addr_r <= {addr_r[SMF_ADDR_W-9:0], byte_in}; // [R2] [R17]
      end
      else if (byte_done && (state_r == SMF_ST_WDATA || state_r == SMF_ST_RDATA))
      begin
         addr_r <= addr_r + 1'b1; // [R1]
      end
   end

   // Storage write on the last data bit: nothing left to wait for
   always_ff @(posedge I_SCK)
   begin
      if (mem_we)
      begin
         mem[addr_r] <= byte_in; // [R12] [R1]
      end
   end

   // Mirror record held stable for a whole byte time
   always_ff @(posedge I_SCK)
   begin
      if (mem_we)
      begin
         wr_hold_r <= '{addr: addr_r, data: byte_in};
         wr_tgl_r <= ~wr_tgl_r;
      end
   end

   // Marks that a rising edge occurred in this frame
   always_ff @(posedge I_SCK or posedge I_CS_N)
   begin
      if (I_CS_N)
      begin
         rise_seen_r <= 1'b0;
      end
      else
      begin
         rise_seen_r <= 1'b1;
      end
   end

   // Output shifter on falling edges; the leading mode 3 fall is skipped
   always_ff @(negedge I_SCK or posedge I_CS_N)
   begin
      if (I_CS_N)
      begin
         out_r <= 8'h00;
         oe_r <= 1'b0; // [R11]
      end
      else if (mode3_r && !rise_seen_r)
      begin
         oe_r <= 1'b0; // [R15]
      end
      else if (state_r == SMF_ST_RDATA)
      begin
         oe_r <= 1'b1;
         if (bit_r == SMF_BIT_RST)
         begin
            out_r <= mem[addr_r]; // [R6] [R17]
         end
         else
         begin
            out_r <= {out_r[6:0], 1'b0}; // [R6]
         end
      end
      else
      begin
         oe_r <= 1'b0; // [R16] [R14]
      end
   end

   assign O_SO = out_r[7];
   assign O_SO_OE = oe_r && !I_CS_N; // [R11]

   // ==========================================================
   // System domain: toggle crossing into the write buffer
   logic tgl_s1_r;
   logic tgl_s2_r;
   logic tgl_s3_r;
   logic tgl_evt;
   logic pend_r;
   smf_wrec_t pend_rec_r;
   logic buf_in_ready;
   logic push;
   logic pop;

   assign tgl_evt = tgl_s2_r ^ tgl_s3_r;

   // The record is stable for about 24 system cycles per byte
   // No reset: the chain keeps tracking the link toggle, so a
   // reset never leaves a false edge behind
   always_ff @(posedge I_CLK)
   begin
      tgl_s1_r <= wr_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
   end

   // Pending stage stalls on a full buffer
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         pend_r <= 1'b0;
         pend_rec_r <= '0;
      end
      else if (tgl_evt && (!pend_r || push))
      begin
         pend_r <= 1'b1;
         pend_rec_r <= wr_hold_r;
      end
      else if (push)
      begin
         pend_r <= 1'b0;
      end
   end

   // Link cannot be stalled, so a lost mirror record is flagged
   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         O_OVERRUN <= 1'b0;
      end
      else if (tgl_evt && pend_r && !push)
      begin
         O_OVERRUN <= 1'b1;
      end
   end

   // ==========================================================
   // Two entry buffer
   localparam int PTR_W = $clog2(BUF_DEPTH);
   smf_wrec_t buf_r [BUF_DEPTH];
   logic [PTR_W-1:0] wp_r;
   logic [PTR_W-1:0] rp_r;
   logic [PTR_W:0] cnt_r;

   assign buf_in_ready = (cnt_r != (PTR_W+1)'(BUF_DEPTH));
   assign push = pend_r && buf_in_ready;
   assign O_WR_VALID = (cnt_r != '0);
   assign pop = O_WR_VALID && I_WR_READY;

   always_ff @(posedge I_CLK)
   begin
      if (push)
      begin
         buf_r[wp_r] <= pend_rec_r;
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (I_SRST)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wp_r <= (wp_r == PTR_W'(BUF_DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop)
         begin
            rp_r <= (rp_r == PTR_W'(BUF_DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end

   assign O_WR_ADDR = buf_r[rp_r].addr;
   assign O_WR_DATA = buf_r[rp_r].data;

endmodule

/* verification/smf_assertions.sv */
/*
 Port checker for smf_top.
 Assumes a bind to every smf_top instance.
*/
`timescale 1ns/1ns
module smf_chk
   import smf_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_SRST,
   input wire logic I_SCK,
   input wire logic I_CS_N,
   input wire logic O_SO,
   input wire logic O_SO_OE,
   input wire logic O_WR_VALID,
   input wire logic I_WR_READY,
   input wire logic [SMF_ADDR_W-1:0] O_WR_ADDR,
   input wire logic [SMF_BYTE_W-1:0] O_WR_DATA,
   input wire logic O_OVERRUN
);
   // =====
   // Checks
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SRST);
   // Deselect must clear the enable register, not only mask it
   oe_off_a: assert property ($past(I_CS_N) |-> !O_SO_OE) else $error("output on while deselected");
   oe_rise_a: assert property ($rose(O_SO_OE) |-> !I_SCK && !I_CS_N) else $error("enable rose off a fall");
   so_fall_a: assert property (O_SO_OE && $changed(O_SO) |-> !I_SCK) else $error("output moved off a fall");
   oe_fall_a: assert property ($fell(O_SO_OE) |-> I_CS_N) else $error("enable fell in frame");
   // Records only come from a frame, never from idle
   self_start_a: assert property ($rose(O_WR_VALID) |-> !$past(I_CS_N, 6)) else $error("record from idle");
   valid_hold_a: assert property (O_WR_VALID && !I_WR_READY |=> $stable({O_WR_VALID, O_WR_ADDR, O_WR_DATA}))
      else $error("record moved while stalled");
   ovr_sticky_a: assert property (O_OVERRUN |=> O_OVERRUN) else $error("overrun flag dropped");
   ovr_set_a: assert property ($rose(O_OVERRUN) |-> $past(O_WR_VALID)) else $error("overrun with room");
   rst_clear_a: assert property ($fell(I_SRST) |-> !O_WR_VALID && !O_OVERRUN) else $error("reset left state");
   cover property (O_OVERRUN);
   cover property (O_WR_VALID && I_WR_READY);
   cover property ($rose(O_SO_OE));
endmodule
bind smf_top smf_chk smf_chk_inst(.I_CLK(I_CLK), .I_SRST(I_SRST), .I_SCK(I_SCK), .I_CS_N(I_CS_N), .O_SO(O_SO),
   .O_SO_OE(O_SO_OE), .O_WR_VALID(O_WR_VALID), .I_WR_READY(I_WR_READY), .O_WR_ADDR(O_WR_ADDR),
   .O_WR_DATA(O_WR_DATA), .O_OVERRUN(O_OVERRUN));

/* verification/smf_spi_master.sv */
/*
 SPI master model, 30 ns serial clock.
 Assumes the bench resolves the tristated data line.
*/
`timescale 1ns/1ns
module smf_spi_master
(
   output logic sck,
   output logic cs_n,
   output logic si,
   input wire logic so
);
   // =====
   // Framing
   initial
   begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end
   task automatic sel(input logic md);
      sck = md;
      #7;
      cs_n = 1'b0;
      #8;
   endtask
   // Short count n leaves a partial byte
   task automatic xbyte(input logic [7:0] b, input int n, output logic [7:0] r);
      r = 8'hxx;
      for (int i = 7; i > 7 - n; i--)
      begin
         sck = 1'b0;
         si = b[i];
         #15;
         sck = 1'b1;
         r[i] = so;
         #15;
      end
   endtask
   // Data line flips once at deselect so stale bits never look valid
   task automatic desel(input logic md);
      #7;
      sck = md;
      #8;
      cs_n = 1'b1;
      si = ~si;
      #30;
   endtask
endmodule

/* verification/tb.sv */
/*
 Bench for smf_top: write, read, bad opcode, partial byte, overrun.
 Assumes the SPI master model and the bound checker.
*/
`timescale 1ns/1ns
module tb;
   import smf_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic rdy = 1'b0;
   logic sck, cs_n, si, so, oe, vld, ovr;
   logic [SMF_ADDR_W-1:0] wa;
   logic [SMF_BYTE_W-1:0] wd;
   logic [7:0] tx [8];
   logic [7:0] rx [8];
   int n_fail = 0;
   int cmp_count = 0;
   wire so_w = oe ? so : 1'bz;
   // =====
   // Harness
   initial
   begin
      forever #5 clk = ~clk;
   end
   smf_top smf_top_inst(.I_CLK(clk), .I_SRST(srst), .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si), .O_SO(so),
      .O_SO_OE(oe), .O_WR_VALID(vld), .I_WR_READY(rdy), .O_WR_ADDR(wa), .O_WR_DATA(wd), .O_OVERRUN(ovr));
   smf_spi_master smf_spi_master_inst(.sck(sck), .cs_n(cs_n), .si(si), .so(so_w));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic report_and_stop();
      if (n_fail == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic rst();
      @(posedge clk) srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // Link edges land 2 ns and 7 ns off the system clock's rising edge
   task automatic run(input logic md, input int n, input int lb);
      @(negedge clk);
      #2;
      smf_spi_master_inst.sel(md);
      for (int i = 0; i < n; i++)
      begin
         smf_spi_master_inst.xbyte(tx[i], (i == n - 1) ? lb : 8, rx[i]);
      end
      smf_spi_master_inst.desel(md);
   endtask
   task automatic pop(input logic [17:0] a, input logic [7:0] d);
      int k;
      k = 0;
      while (vld !== 1'b1 && k < 50)
      begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(wa, a);
      chk(wd, d);
      @(posedge clk) rdy <= 1'b1;
      @(posedge clk) rdy <= 1'b0;
      #1;
   endtask
   // =====
   // Scenarios
   task automatic t_wr_rd();
      tx = '{SMF_OP_WRITE, 8'hff, 8'hff, 8'hfe, 8'ha5, 8'h3c, 8'h5a, 8'h00};
      run(1'b0, 7, 8);
      pop(18'h3fffe, 8'ha5);
      pop(18'h3ffff, 8'h3c);
      pop(18'h00000, 8'h5a);
      chk(ovr, 1'b0);
      tx = '{SMF_OP_READ, 8'h03, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00};
      run(1'b1, 7, 8);
      chk(rx[3], 8'hzz);
      chk(rx[4], 8'ha5);
      chk(rx[5], 8'h3c);
      chk(rx[6], 8'h5a);
   endtask
   task automatic t_bad();
      tx = '{8'h9a, SMF_OP_READ, 8'h03, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00};
      run(1'b0, 6, 8);
      chk(rx[5], 8'hzz);
      chk(vld, 1'b0);
   endtask
   task automatic t_part();
      tx = '{SMF_OP_WRITE, 8'h00, 8'h00, 8'h00, 8'hc3, 8'h00, 8'h00, 8'h00};
      run(1'b0, 5, 5);
      repeat (20) @(posedge clk);
      chk(vld, 1'b0);
      tx[0] = SMF_OP_READ;
      run(1'b1, 5, 8);
      chk(rx[4], 8'h5a);
   endtask
   task automatic t_ovr();
      tx = '{SMF_OP_WRITE, 8'h00, 8'h00, 8'h10, 8'h01, 8'h02, 8'h03, 8'h04};
      run(1'b0, 8, 8);
      repeat (20) @(posedge clk);
      chk(ovr, 1'b1);
      pop(18'h00010, 8'h01);
      rst();
      chk(ovr, 1'b0);
      chk(vld, 1'b0);
   endtask
   // Warm-up frame; its record is flushed by the reset that follows
   initial
   begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      tx = '{SMF_OP_WRITE, 8'h00, 8'h00, 8'h00, 8'h77, 8'h00, 8'h00, 8'h00};
      run(1'b0, 5, 8);
      rst();
      t_wr_rd();
      t_bad();
      t_part();
      t_ovr();
      report_and_stop();
   end
   initial
   begin
      #100000;
      n_fail++;
      report_and_stop();
   end
endmodule
